// [rtl/lph_host.sv]
// host end of a serial display link: clock lane and data lane 0 drivers
// Contract
// - clock ultra-low exit via LP-10, LP-11
// - clock ultra-low entry LP-11, LP-10, LP-00
// - clock high speed via LP-01, LP-00, HS-0
// - clock runs before and after data bursts
// - clock burst starts HS-0, even transitions
// - escape and turnaround only on lane 0
// - turnaround LP-10, 00, 10, 00 then release
// - escape entry 10,00,01,00; mark-1 exit
// - data burst ends with trail then LP-11
// - low-power data command is 1110 0001
// - payload bytes, low-low pause between bytes
// - ultra-low command holds lane 0 until mark-1
// - ultra-low escape code is 0001 1110
// - remote reset code is 0110 0010
// - tearing trigger code is 0101 1101
// - acknowledge code is 0010 0001
`timescale 1ns/1ps
module lph_host (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       cmd_valid_i,
	input  wire logic [3:0] cmd_i,
	output logic            cmd_ready_o,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_last_i,
	input  wire logic       tx_valid_i,
	output logic            tx_ready_o,
	input  wire logic       d0_p_i,
	input  wire logic       d0_n_i,
	output logic            d0_p_o,
	output logic            d0_n_o,
	output logic            d0_oe_o,
	output logic            d0_hs_o,
	output logic            d0_hs_en_o,
	output logic            ck_p_o,
	output logic            ck_n_o,
	output logic            ck_hs_o,
	output logic            ck_hs_en_o,
	output logic [7:0]      rx_data_o,
	output logic            rx_valid_o,
	output logic            rx_te_o,
	output logic            rx_ack_o
);
	typedef struct packed {
		logic [1:0]         s1;
		logic [1:0]         s2;
		logic [3:0]         div;
		logic               tick;
		lph_pkg::lph_lane_t l;
		lph_pkg::lph_clk_t  c;
		logic [7:0]         sh;
		logic [2:0]         bcnt;
		logic               lsbf;
		logic               cur_last;
		logic [1:0]         post;
		logic [7:0]         nb;
		logic               nb_last;
		logic               nb_full;
		logic               stop_req;
		logic [1:0]         pn;
		logic               oe;
		logic               hs;
		logic               hs_en;
		logic [1:0]         ck;
		logic               ck_hs;
		logic               ck_hs_en;
		logic               cmd_rdy;
		logic               tx_rdy;
		logic [7:0]         rx_data;
		logic               rx_valid;
		logic               te;
		logic               ack;
	} host_st_t;

	// what follows the command byte
	localparam logic [1:0] POST_EXIT = 2'h0;
	localparam logic [1:0] POST_DATA = 2'h1;
	localparam logic [1:0] POST_ULPS = 2'h2;

	host_st_t r;
	host_st_t next_r;
	logic     take;
	logic     byte_in;
	logic     bit_o;
	lph_rx_if rxi ();

	lph_esc_rx u_rx (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.rx    (rxi)
	);

	// receiver only listens while the device owns the lane
	assign rxi.en = (r.l == lph_pkg::L_REL);
	assign rxi.p  = r.s2[1];
	assign rxi.n  = r.s2[0];

	assign take    = cmd_valid_i && r.cmd_rdy;
	assign byte_in = tx_valid_i && r.tx_rdy;
	assign bit_o   = r.lsbf ? r.sh[0] : r.sh[7];

	// both lane machines, the step divider and the pin images
	always_comb begin
		next_r          = r;
		next_r.s1       = {d0_p_i, d0_n_i};
		next_r.s2       = r.s1;
		next_r.tick     = (r.div == lph_pkg::STEP_LAST);
		next_r.div      = next_r.tick ? lph_pkg::DIV_RST : r.div + 4'h1;
		next_r.rx_data  = rxi.data;
		next_r.rx_valid = rxi.data_valid;
		next_r.te       = rxi.te;
		next_r.ack      = rxi.ack;
		if (byte_in) begin
			next_r.nb      = tx_data_i;
			next_r.nb_last = tx_last_i;
			next_r.nb_full = 1'b1;
		end
		// commands are taken at once and stepped out on ticks
		if (take) begin
			case (lph_pkg::lph_cmd_t'(cmd_i))
			lph_pkg::CMD_LPDT, lph_pkg::CMD_ULPS, lph_pkg::CMD_RESET: begin
				if (r.l == lph_pkg::L_IDLE) begin
					next_r.l    = lph_pkg::L_E10;
					next_r.lsbf = 1'b0;
					next_r.bcnt = 3'h0;
					next_r.sh   = lph_pkg::ESC_RESET;
					next_r.post = POST_EXIT;
					if (cmd_i == lph_pkg::CMD_LPDT) begin
						next_r.sh   = lph_pkg::ESC_LPDT;
						next_r.post = POST_DATA;
					end else if (cmd_i == lph_pkg::CMD_ULPS) begin
						next_r.sh   = lph_pkg::ESC_ULPS;
						next_r.post = POST_ULPS;
					end
				end
			end
			lph_pkg::CMD_TURN: begin
				if (r.l == lph_pkg::L_IDLE) next_r.l = lph_pkg::L_T10A;
			end
			lph_pkg::CMD_HSDT: begin
				// data needs a running high-speed clock, else the command is dropped
				if (r.l == lph_pkg::L_IDLE && r.c == lph_pkg::C_HS) begin
					next_r.l = lph_pkg::L_H01;
				end
			end
			lph_pkg::CMD_CLK_HS: begin
				if (r.c == lph_pkg::C_STOP) next_r.c = lph_pkg::C_H01;
			end
			lph_pkg::CMD_CLK_LP: begin
				// lane idle here, so the clock outlives the burst
				if (r.c == lph_pkg::C_HS) next_r.stop_req = 1'b1;
			end
			lph_pkg::CMD_CLK_ULPS: begin
				if (r.c == lph_pkg::C_STOP) next_r.c = lph_pkg::C_U10;
			end
			lph_pkg::CMD_WAKE: begin
				if (r.l == lph_pkg::L_ULPS) next_r.l = lph_pkg::L_X10;
				if (r.c == lph_pkg::C_ULPS) next_r.c = lph_pkg::C_W10;
			end
			default: begin
				next_r.l = r.l;
			end
			endcase
		end
		// data lane 0 steps
		if (r.tick) begin
			case (r.l)
			lph_pkg::L_E10: begin
				next_r.pn = lph_pkg::LP_10;
				next_r.l  = lph_pkg::L_E00A;
			end
			lph_pkg::L_E00A: begin
				next_r.pn = lph_pkg::LP_00;
				next_r.l  = lph_pkg::L_E01;
			end
			lph_pkg::L_E01: begin
				next_r.pn = lph_pkg::LP_01;
				next_r.l  = lph_pkg::L_E00B;
			end
			lph_pkg::L_E00B: begin
				next_r.pn = lph_pkg::LP_00;
				next_r.l  = lph_pkg::L_BHI;
			end
			lph_pkg::L_BHI: begin
				// a one pulses the positive wire, a zero the negative
				next_r.pn = bit_o ? lph_pkg::LP_10 : lph_pkg::LP_01;
				next_r.l  = lph_pkg::L_BLO;
			end
			lph_pkg::L_BLO: begin
				next_r.pn   = lph_pkg::LP_00;
				next_r.sh   = r.lsbf ? {1'b0, r.sh[7:1]} : {r.sh[6:0], 1'b0};
				next_r.bcnt = r.bcnt + 3'h1;
				next_r.l    = lph_pkg::L_BHI;
				if (r.bcnt == lph_pkg::BIT_LAST) begin
					if (r.lsbf) begin
						next_r.l = r.cur_last ? lph_pkg::L_X10 : lph_pkg::L_PAUSE;
					end else if (r.post == POST_DATA) begin
						next_r.l = lph_pkg::L_PAUSE;
					end else if (r.post == POST_ULPS) begin
						next_r.l = lph_pkg::L_ULPS;
					end else begin
						next_r.l = lph_pkg::L_X10;
					end
				end
			end
			lph_pkg::L_PAUSE: begin
				// line rests low-low until the next byte arrives
				if (r.nb_full) begin
					next_r.sh       = r.nb;
					next_r.cur_last = r.nb_last;
					next_r.nb_full  = 1'b0;
					next_r.lsbf     = 1'b1;
					next_r.bcnt     = 3'h0;
					next_r.l        = lph_pkg::L_BHI;
				end
			end
			lph_pkg::L_ULPS: begin
				next_r.pn = lph_pkg::LP_00;
			end
			lph_pkg::L_X10: begin
				next_r.pn = lph_pkg::LP_10;
				next_r.l  = lph_pkg::L_IDLE;
			end
			lph_pkg::L_IDLE: begin
				next_r.pn = lph_pkg::LP_11;
			end
			lph_pkg::L_T10A, lph_pkg::L_T10B: begin
				next_r.pn = lph_pkg::LP_10;
				next_r.l  = (r.l == lph_pkg::L_T10A) ? lph_pkg::L_T00A
				                                   : lph_pkg::L_T00B;
			end
			lph_pkg::L_T00A: begin
				next_r.pn = lph_pkg::LP_00;
				next_r.l  = lph_pkg::L_T10B;
			end
			lph_pkg::L_T00B: begin
				next_r.pn = lph_pkg::LP_00;
				next_r.l  = lph_pkg::L_REL;
			end
			lph_pkg::L_REL: begin
				next_r.oe = 1'b0;
			end
			lph_pkg::L_H01: begin
				next_r.pn = lph_pkg::LP_01;
				next_r.l  = lph_pkg::L_H00;
			end
			lph_pkg::L_H00: begin
				next_r.pn = lph_pkg::LP_00;
				next_r.l  = lph_pkg::L_HS0;
			end
			lph_pkg::L_HS0: begin
				next_r.hs_en = 1'b1;
				next_r.hs    = 1'b0;
				next_r.sh    = lph_pkg::HS_SYNC;
				next_r.lsbf  = 1'b0;
				next_r.bcnt  = 3'h0;
				next_r.cur_last = 1'b0;
				next_r.l     = lph_pkg::L_HDATA;
			end
			lph_pkg::L_HDATA: begin
				next_r.hs   = bit_o;
				next_r.sh   = r.lsbf ? {1'b0, r.sh[7:1]} : {r.sh[6:0], 1'b0};
				next_r.bcnt = r.bcnt + 3'h1;
				if (r.bcnt == lph_pkg::BIT_LAST) begin
					// an empty buffer at a byte edge ends the burst
					if (!r.cur_last && r.nb_full) begin
						next_r.sh       = r.nb;
						next_r.cur_last = r.nb_last;
						next_r.nb_full  = 1'b0;
						next_r.lsbf     = 1'b1;
					end else begin
						next_r.l = lph_pkg::L_HTRAIL;
					end
				end
			end
			lph_pkg::L_HTRAIL: begin
				next_r.hs = ~r.hs;
				next_r.l  = lph_pkg::L_HEND;
			end
			lph_pkg::L_HEND: begin
				next_r.hs_en = 1'b0;
				next_r.hs    = 1'b0;
				next_r.pn    = lph_pkg::LP_11;
				next_r.l     = lph_pkg::L_IDLE;
			end
			default: begin
				next_r.l = r.l;
			end
			endcase
		end
		// device hands the lane back with its own turnaround
		if (r.l == lph_pkg::L_REL && rxi.turn_done) begin
			next_r.oe = 1'b1;
			next_r.pn = lph_pkg::LP_11;
			next_r.l  = lph_pkg::L_IDLE;
		end
		// clock lane steps
		if (r.tick) begin
			case (r.c)
			lph_pkg::C_U10: begin
				next_r.ck = lph_pkg::LP_10;
				next_r.c  = lph_pkg::C_ULPS;
			end
			lph_pkg::C_ULPS: begin
				next_r.ck = lph_pkg::LP_00;
			end
			lph_pkg::C_W10: begin
				next_r.ck = lph_pkg::LP_10;
				next_r.c  = lph_pkg::C_STOP;
			end
			lph_pkg::C_STOP: begin
				next_r.ck = lph_pkg::LP_11;
			end
			lph_pkg::C_H01: begin
				next_r.ck = lph_pkg::LP_01;
				next_r.c  = lph_pkg::C_H00;
			end
			lph_pkg::C_H00: begin
				next_r.ck = lph_pkg::LP_00;
				next_r.c  = lph_pkg::C_HS0;
			end
			lph_pkg::C_HS0: begin
				next_r.ck_hs_en = 1'b1;
				next_r.ck_hs    = 1'b0;
				next_r.c        = lph_pkg::C_HS;
			end
			lph_pkg::C_HS: begin
				// stop only on a fall back to HS-0: even transition count
				next_r.ck_hs = ~r.ck_hs;
				if (r.stop_req && r.ck_hs) next_r.c = lph_pkg::C_HEND;
			end
			lph_pkg::C_HEND: begin
				next_r.ck_hs_en = 1'b0;
				next_r.ck       = lph_pkg::LP_11;
				next_r.stop_req = 1'b0;
				next_r.c        = lph_pkg::C_STOP;
			end
			default: begin
				next_r.c = r.c;
			end
			endcase
		end
		// ready only at rest levels or with the clock running high speed, else a quick command cuts mark-1
		next_r.cmd_rdy = ((next_r.l == lph_pkg::L_IDLE
		                   && next_r.pn == lph_pkg::LP_11)
		                  || next_r.l == lph_pkg::L_ULPS)
		                 && !next_r.stop_req
		                 && ((next_r.c == lph_pkg::C_STOP
		                      && next_r.ck == lph_pkg::LP_11)
		                     || next_r.c == lph_pkg::C_HS
		                     || (next_r.c == lph_pkg::C_ULPS
		                         && next_r.ck == lph_pkg::LP_00));
		next_r.tx_rdy  = !next_r.nb_full
		                 && (next_r.l == lph_pkg::L_PAUSE
		                     || next_r.l == lph_pkg::L_BHI
		                     || next_r.l == lph_pkg::L_BLO
		                     || next_r.l == lph_pkg::L_HS0
		                     || next_r.l == lph_pkg::L_HDATA)
		                 && (next_r.post == POST_DATA
		                     || next_r.l == lph_pkg::L_HS0
		                     || next_r.l == lph_pkg::L_HDATA);
	end

	// state register; lanes wake in stop with lane 0 driven
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '{l: lph_pkg::L_IDLE, c: lph_pkg::C_STOP,
			       pn: lph_pkg::LP_11, ck: lph_pkg::LP_11,
			       s1: lph_pkg::LP_11, s2: lph_pkg::LP_11,
			       oe: 1'b1, div: lph_pkg::DIV_RST, cmd_rdy: 1'b1,
			       default: '0};
		end else begin
			r <= next_r;
		end
	end

	assign cmd_ready_o = r.cmd_rdy;
	assign tx_ready_o  = r.tx_rdy;
	assign d0_p_o      = r.pn[1];
	assign d0_n_o      = r.pn[0];
	assign d0_oe_o     = r.oe;
	assign d0_hs_o     = r.hs;
	assign d0_hs_en_o  = r.hs_en;
	assign ck_p_o      = r.ck[1];
	assign ck_n_o      = r.ck[0];
	assign ck_hs_o     = r.ck_hs;
	assign ck_hs_en_o  = r.ck_hs_en;
	assign rx_data_o   = r.rx_data;
	assign rx_valid_o  = r.rx_valid;
	assign rx_te_o     = r.te;
	assign rx_ack_o    = r.ack;
endmodule : lph_host

// [rtl/lph_pkg.sv]
// constants and types shared by the low-power link host controller
package lph_pkg;

	// timing: one line step per divider tick
	localparam int CLK_PERIOD_NS = 20;
	localparam int STEP_NS       = 80;
	localparam int STEP_CYC      = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] STEP_LAST = 4'(STEP_CYC - 1);
	localparam logic [3:0] DIV_RST   = 4'h0;

	// single-ended line states, bit 1 = positive wire, bit 0 = negative
	localparam logic [1:0] LP_00 = 2'h0;
	localparam logic [1:0] LP_01 = 2'h1;
	localparam logic [1:0] LP_10 = 2'h2;
	localparam logic [1:0] LP_11 = 2'h3;

	// escape command and trigger patterns, first bit sent is bit 7
	localparam logic [7:0] ESC_LPDT  = 8'he1;
	localparam logic [7:0] ESC_ULPS  = 8'h1e;
	localparam logic [7:0] ESC_RESET = 8'h62;
	localparam logic [7:0] ESC_TE    = 8'h5d;
	localparam logic [7:0] ESC_ACK   = 8'h21;
	localparam logic [7:0] ESC_UNS1  = 8'h9f;
	localparam logic [7:0] ESC_UNS2  = 8'hde;
	localparam logic [7:0] ESC_UNS3  = 8'ha0;
	// high-speed leader, sent first bit = bit 7
	localparam logic [7:0] HS_SYNC   = 8'h1d;
	localparam logic [2:0] BIT_LAST  = 3'h7;

	// host commands
	typedef enum logic [3:0] {
		CMD_LPDT     = 4'h0,
		CMD_ULPS     = 4'h1,
		CMD_RESET    = 4'h2,
		CMD_TURN     = 4'h3,
		CMD_HSDT     = 4'h4,
		CMD_CLK_HS   = 4'h5,
		CMD_CLK_LP   = 4'h6,
		CMD_WAKE     = 4'h7,
		CMD_CLK_ULPS = 4'h8
	} lph_cmd_t;

	// data lane 0 transmitter states
	typedef enum logic [4:0] {
		L_IDLE   = 5'h00,
		L_E10    = 5'h01,
		L_E00A   = 5'h02,
		L_E01    = 5'h03,
		L_E00B   = 5'h04,
		L_BHI    = 5'h05,
		L_BLO    = 5'h06,
		L_PAUSE  = 5'h07,
		L_ULPS   = 5'h08,
		L_X10    = 5'h09,
		L_T10A   = 5'h0a,
		L_T00A   = 5'h0b,
		L_T10B   = 5'h0c,
		L_T00B   = 5'h0d,
		L_REL    = 5'h0e,
		L_H01    = 5'h0f,
		L_H00    = 5'h10,
		L_HS0    = 5'h11,
		L_HDATA  = 5'h12,
		L_HTRAIL = 5'h13,
		L_HEND   = 5'h14
	} lph_lane_t;

	// clock lane states
	typedef enum logic [3:0] {
		C_STOP = 4'h0,
		C_U10  = 4'h1,
		C_ULPS = 4'h2,
		C_W10  = 4'h3,
		C_H01  = 4'h4,
		C_H00  = 4'h5,
		C_HS0  = 4'h6,
		C_HS   = 4'h7,
		C_HEND = 4'h8
	} lph_clk_t;

	// escape receiver states
	typedef enum logic [3:0] {
		R_STOP = 4'h0,
		R_A10  = 4'h1,
		R_A00  = 4'h2,
		R_E01  = 4'h3,
		R_B10  = 4'h4,
		R_SP   = 4'h5,
		R_P1   = 4'h6,
		R_P0   = 4'h7,
		R_WAIT = 4'h8
	} lph_rx_t;

endpackage : lph_pkg

// [rtl/lph_rx_if.sv]
// link between the lane controller and its escape receiver
`timescale 1ns/1ps
interface lph_rx_if;
	logic       en;
	logic       p;
	logic       n;
	logic [7:0] data;
	logic       data_valid;
	logic       te;
	logic       ack;
	logic       turn_done;

	modport rx (
		input  en,
		input  p,
		input  n,
		output data,
		output data_valid,
		output te,
		output ack,
		output turn_done
	);
	modport ctl (
		output en,
		output p,
		output n,
		input  data,
		input  data_valid,
		input  te,
		input  ack,
		input  turn_done
	);
endinterface : lph_rx_if

// [rtl/lph_esc_rx.sv]
// escape decoder for data lane 0 while the device owns it
`timescale 1ns/1ps
module lph_esc_rx (
	input  wire logic clk_i,
	input  wire logic rst_i,
	lph_rx_if.rx      rx
);
	typedef struct packed {
		lph_pkg::lph_rx_t st;
		logic [7:0]       sh;
		logic [2:0]       bcnt;
		logic             payload;
		logic [7:0]       data;
		logic             dv;
		logic             te;
		logic             ack;
		logic             turn;
	} rx_st_t;

	rx_st_t     r;
	rx_st_t     next_r;
	logic [1:0] ln;
	logic       bit_v;
	logic       bit_seen;
	logic [7:0] v;

	assign ln = {rx.p, rx.n};

	// line walker: entry sequences, pulse bits, command compare
	always_comb begin
		next_r      = r;
		next_r.dv   = 1'b0;
		next_r.te   = 1'b0;
		next_r.ack  = 1'b0;
		next_r.turn = 1'b0;
		bit_v       = 1'b0;
		bit_seen    = 1'b0;
		v           = r.sh;
		case (r.st)
		lph_pkg::R_STOP: begin
			if (ln == lph_pkg::LP_10) next_r.st = lph_pkg::R_A10;
		end
		lph_pkg::R_A10: begin
			if (ln == lph_pkg::LP_00) next_r.st = lph_pkg::R_A00;
			else if (ln == lph_pkg::LP_01) next_r.st = lph_pkg::R_WAIT;
		end
		lph_pkg::R_A00: begin
			if (ln == lph_pkg::LP_01) next_r.st = lph_pkg::R_E01;
			else if (ln == lph_pkg::LP_10) next_r.st = lph_pkg::R_B10;
		end
		lph_pkg::R_E01: begin
			if (ln == lph_pkg::LP_00) begin
				next_r.st      = lph_pkg::R_SP;
				next_r.bcnt    = 3'h0;
				next_r.payload = 1'b0;
			end else if (ln == lph_pkg::LP_10) begin
				next_r.st = lph_pkg::R_WAIT;
			end
		end
		lph_pkg::R_B10: begin
			if (ln == lph_pkg::LP_00) begin
				next_r.turn = 1'b1;
				next_r.st   = lph_pkg::R_WAIT;
			end
		end
		lph_pkg::R_SP: begin
			// both low between bytes is a pause, not an end
			if (ln == lph_pkg::LP_10) next_r.st = lph_pkg::R_P1;
			else if (ln == lph_pkg::LP_01) next_r.st = lph_pkg::R_P0;
		end
		lph_pkg::R_P1, lph_pkg::R_P0: begin
			// the falling half of the pulse clocks the bit
			if (ln == lph_pkg::LP_00) begin
				bit_seen  = 1'b1;
				bit_v     = (r.st == lph_pkg::R_P1);
				next_r.st = lph_pkg::R_SP;
			end
		end
		default: begin
			next_r.st = r.st;
		end
		endcase
		if (bit_seen) begin
			// commands first bit to last as written, payload lsb first
			v           = r.payload ? {bit_v, r.sh[7:1]} : {r.sh[6:0], bit_v};
			next_r.sh   = v;
			next_r.bcnt = r.bcnt + 3'h1;
			if (r.bcnt == lph_pkg::BIT_LAST) begin
				if (r.payload) begin
					next_r.data = v;
					next_r.dv   = 1'b1;
				end else if (v == lph_pkg::ESC_LPDT) begin
					next_r.payload = 1'b1;
				end else begin
					// triggers and unknown codes wait in R_WAIT for the stop state
					next_r.te  = (v == lph_pkg::ESC_TE);
					next_r.ack = (v == lph_pkg::ESC_ACK);
					next_r.st  = lph_pkg::R_WAIT;
				end
			end
		end
		// stop state aborts any partial sequence
		if (!rx.en || ln == lph_pkg::LP_11) begin
			next_r.st = lph_pkg::R_STOP;
		end
	end

	// state register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '{st: lph_pkg::R_STOP, default: '0};
		end else begin
			r <= next_r;
		end
	end

	assign rx.data       = r.data;
	assign rx.data_valid = r.dv;
	assign rx.te         = r.te;
	assign rx.ack        = r.ack;
	assign rx.turn_done  = r.turn;
endmodule : lph_esc_rx

// [sim/lph_host_sva.sv]
// concurrent checks on the lane pins of the link host controller
`timescale 1ns/1ps
module lph_host_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic d0_p_o,
	input wire logic d0_n_o,
	input wire logic d0_oe_o,
	input wire logic d0_hs_o,
	input wire logic d0_hs_en_o,
	input wire logic ck_p_o,
	input wire logic ck_n_o,
	input wire logic ck_hs_o,
	input wire logic ck_hs_en_o,
	input wire logic rx_valid_o,
	input wire logic rx_te_o,
	input wire logic rx_ack_o
);
	logic [1:0] d0;
	logic [1:0] ck;

	// pairs as state codes, positive wire in the upper bit
	assign d0 = {d0_p_o, d0_n_o};
	assign ck = {ck_p_o, ck_n_o};

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// each state holds one 4-cycle step, hence the depth of 5
	a_ck_hs_entry: assert property ($rose(ck_hs_en_o) |->
		!ck_hs_o && $past(ck) == 2'h0 && $past(ck, 5) == 2'h1)
		else $error("clock burst entry wrong");
	a_ck_burst_end: assert property ($fell(ck_hs_en_o) |->
		!$past(ck_hs_o) && $past(ck_hs_o, 5))
		else $error("clock burst did not end on HS-0");
	a_ck_one_wire: assert property ($changed(ck) && !ck_hs_en_o &&
		!$past(ck_hs_en_o) |-> $countones(ck ^ $past(ck)) == 1)
		else $error("clock lane skipped a state");
	a_ck_outlives: assert property ($fell(ck_hs_en_o) |->
		!$past(d0_hs_en_o) && !$past(d0_hs_en_o, 4))
		else $error("clock stopped under data burst");
	a_d0_hs_entry: assert property ($rose(d0_hs_en_o) |->
		ck_hs_en_o && !d0_hs_o && $past(d0) == 2'h0 && $past(d0, 5) == 2'h1)
		else $error("data burst entry wrong");
	a_d0_trail: assert property ($fell(d0_hs_en_o) |->
		d0 == 2'h3 && $past(d0_hs_o) != $past(d0_hs_o, 5))
		else $error("data burst end wrong");
	a_d0_one_wire: assert property ($changed(d0) && d0_oe_o &&
		$past(d0_oe_o) && !d0_hs_en_o && !$past(d0_hs_en_o)
		|-> $countones(d0 ^ $past(d0)) == 1)
		else $error("lane 0 skipped a state");
	a_turn_release: assert property ($fell(d0_oe_o) |->
		$past(d0) == 2'h0 && $past(d0, 5) == 2'h2 && $past(d0, 9) == 2'h0)
		else $error("lane released without turnaround");
	a_rx_released: assert property (rx_te_o || rx_ack_o || rx_valid_o
		|-> !$past(d0_oe_o))
		else $error("receive while host drives lane");
endmodule : lph_host_sva

bind lph_host lph_host_sva chk (
	.clk_i(clk_i), .rst_i(rst_i), .d0_p_o(d0_p_o), .d0_n_o(d0_n_o),
	.d0_oe_o(d0_oe_o), .d0_hs_o(d0_hs_o), .d0_hs_en_o(d0_hs_en_o),
	.ck_p_o(ck_p_o), .ck_n_o(ck_n_o), .ck_hs_o(ck_hs_o),
	.ck_hs_en_o(ck_hs_en_o), .rx_valid_o(rx_valid_o), .rx_te_o(rx_te_o),
	.rx_ack_o(rx_ack_o)
);

// [sim/lph_dev_model.sv]
// display end of lane 0: decodes host escapes, replies after turnaround
`timescale 1ns/1ps
module lph_dev_model (
	input  wire logic clk_i,
	input  wire logic hp_i,
	input  wire logic hn_i,
	input  wire logic hoe_i,
	output logic      p_o,
	output logic      n_o
);
	logic [1:0] prev = 2'h3;
	logic [9:0] hist = 10'h3ff;
	logic       esc  = 1'b0;
	logic       own  = 1'b0;
	logic [1:0] dl   = 2'h3;
	logic [1:0] fl   = 2'h1;
	logic [7:0] sr   = 8'h00;
	logic [7:0] pb   = 8'h00;
	logic [7:0] cmd  = 8'h00;
	int         nb   = 0;
	logic [7:0] got[$];

	// undriven lane flips every cycle so a stale level never passes
	always @(posedge clk_i) fl <= ~fl;
	assign {p_o, n_o} = hoe_i ? {hp_i, hn_i} : (own ? dl : fl);

	// low-power receiver acts on every change of the host's state
	always @(posedge clk_i) begin
		if (hoe_i && {hp_i, hn_i} != prev) begin
			hist = {hist[7:0], hp_i, hn_i};
			if (hist[1:0] == 2'h3) esc = 1'b0;
			else if (hist == 10'b1110000100) begin
				esc = 1'b1;
				nb = 0;
			end else if (!esc && hist == 10'b1110001000) begin
				own = 1'b1;
				dl = 2'h3;
			end else if (esc && hist[1:0] == 2'h0) begin
				nb++;
				if (nb <= 8) sr = {sr[6:0], prev[1]};
				else pb = {prev[1], pb[7:1]};
				if (nb == 8) cmd = sr;
				if (nb == 8 && sr == lph_pkg::ESC_RESET) got.delete();
				if (nb > 8 && nb % 8 == 0) got.push_back(pb);
			end
			prev = {hp_i, hn_i};
		end
	end

	// one line state per step, pulse plus space is one 160 ns period
	task automatic put(input logic [1:0] s);
		@(posedge clk_i);
		#1 dl = s;
		repeat (3) @(posedge clk_i);
	endtask : put

	// escape with nb_c command bits; short count aborts through stop
	task automatic reply(input logic [7:0] c, input logic [7:0] d,
		input int nb_c, input bit wd, input bit last);
		put(2'h2); put(2'h0); put(2'h1); put(2'h0);
		for (int i = 7; i >= 8 - nb_c; i--) begin
			put(c[i] ? 2'h2 : 2'h1);
			put(2'h0);
		end
		for (int i = 0; i < 8 && wd; i++) begin
			put(d[i] ? 2'h2 : 2'h1);
			put(2'h0);
		end
		if (nb_c == 8) put(2'h2);
		put(2'h3);
		if (last) begin
			put(2'h2); put(2'h0); put(2'h2); put(2'h0);
			own = 1'b0;
		end
	endtask : reply
endmodule : lph_dev_model

// [sim/lph_host_bench.sv]
// self-checking bench for the link host controller
`timescale 1ns/1ps
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin \
	n_fail++; $display("MISMATCH %0t %s", $time, m); end end
module lph_host_bench;
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       cmd_valid_i = 1'b0;
	logic [3:0] cmd_i = 4'h0;
	logic [7:0] tx_data_i = 8'h00;
	logic       tx_last_i = 1'b0;
	logic       tx_valid_i = 1'b0;
	logic       cmd_ready_o, tx_ready_o, d0_p_i, d0_n_i, d0_p_o, d0_n_o;
	logic       d0_oe_o, d0_hs_o, d0_hs_en_o, ck_p_o, ck_n_o, ck_hs_o;
	logic       ck_hs_en_o, rx_valid_o, rx_te_o, rx_ack_o;
	logic [7:0] rx_data_o;
	logic [7:0] rxq[$];
	int         n_fail = 0;
	int         checks_done = 0;
	int         n_te = 0;
	int         n_ack = 0;

	always #10 clk_i = ~clk_i;

	lph_host dut (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
		.cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .tx_data_i(tx_data_i),
		.tx_last_i(tx_last_i), .tx_valid_i(tx_valid_i),
		.tx_ready_o(tx_ready_o), .d0_p_i(d0_p_i), .d0_n_i(d0_n_i),
		.d0_p_o(d0_p_o), .d0_n_o(d0_n_o), .d0_oe_o(d0_oe_o),
		.d0_hs_o(d0_hs_o), .d0_hs_en_o(d0_hs_en_o), .ck_p_o(ck_p_o),
		.ck_n_o(ck_n_o), .ck_hs_o(ck_hs_o), .ck_hs_en_o(ck_hs_en_o),
		.rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
		.rx_te_o(rx_te_o), .rx_ack_o(rx_ack_o));
	lph_dev_model dev (.clk_i(clk_i), .hp_i(d0_p_o), .hn_i(d0_n_o),
		.hoe_i(d0_oe_o), .p_o(d0_p_i), .n_o(d0_n_i));

	// one-cycle receive pulses are counted where they stand
	always @(posedge clk_i) begin
		if (rx_te_o === 1'b1) n_te++;
		if (rx_ack_o === 1'b1) n_ack++;
		if (rx_valid_o === 1'b1) rxq.push_back(rx_data_o);
	end

	task automatic issue(input logic [3:0] c);
		cmd_i = c;
		cmd_valid_i = 1'b1;
		do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
		#1 cmd_valid_i = 1'b0;
	endtask : issue

	task automatic feed(input logic [7:0] b, input logic l);
		tx_data_i = b;
		tx_last_i = l;
		tx_valid_i = 1'b1;
		do @(posedge clk_i); while (tx_ready_o !== 1'b1);
		#1 tx_valid_i = 1'b0;
	endtask : feed

	// ready drops at the take edge itself; still look two edges later
	task automatic settle();
		int k;
		k = 0;
		repeat (2) @(posedge clk_i);
		while (cmd_ready_o !== 1'b1 && k < 2000) begin
			@(posedge clk_i);
			k++;
		end
		`CHK(cmd_ready_o, 1'b1, "command never finished")
		#1;
	endtask : settle

	task automatic wait_oe(input logic v);
		for (int k = 0; k < 400 && d0_oe_o !== v; k++) @(posedge clk_i);
		`CHK(d0_oe_o, v, "lane ownership wrong")
	endtask : wait_oe

	task automatic t_escapes();
		issue(lph_pkg::CMD_RESET);
		settle();
		`CHK(dev.cmd, lph_pkg::ESC_RESET, "reset code")
		issue(lph_pkg::CMD_LPDT);
		feed(8'ha5, 1'b0);
		repeat (40) @(posedge clk_i);
		#1 feed(8'h3c, 1'b1);
		settle();
		`CHK(dev.cmd, lph_pkg::ESC_LPDT, "data code")
		`CHK(dev.got.size(), 2, "byte count")
		`CHK({dev.got[0], dev.got[1]}, 16'ha53c, "payload")
		issue(lph_pkg::CMD_ULPS);
		settle();
		`CHK(dev.cmd, lph_pkg::ESC_ULPS, "ulps code")
		`CHK({d0_p_o, d0_n_o}, lph_pkg::LP_00, "ulps hold")
		issue(lph_pkg::CMD_WAKE);
		settle();
		`CHK({d0_p_o, d0_n_o}, lph_pkg::LP_11, "ulps exit")
	endtask : t_escapes

	task automatic t_clock();
		issue(lph_pkg::CMD_HSDT);
		settle();
		`CHK(d0_hs_en_o, 1'b0, "burst without clock")
		issue(lph_pkg::CMD_CLK_HS);
		settle();
		`CHK(ck_hs_en_o, 1'b1, "clock not in burst")
		issue(lph_pkg::CMD_HSDT);
		feed(8'h5a, 1'b1);
		settle();
		`CHK({d0_hs_en_o, d0_p_o, d0_n_o}, 3'h3, "burst end")
		issue(lph_pkg::CMD_CLK_LP);
		settle();
		`CHK({ck_hs_en_o, ck_p_o, ck_n_o}, 3'h3, "clock stop")
		issue(lph_pkg::CMD_CLK_ULPS);
		settle();
		`CHK({ck_p_o, ck_n_o}, lph_pkg::LP_00, "clock ulps")
		issue(lph_pkg::CMD_WAKE);
		settle();
		`CHK({ck_p_o, ck_n_o}, lph_pkg::LP_11, "clock wake")
	endtask : t_clock

	// device answers; an aborted and three unknown codes do nothing
	task automatic t_turn();
		logic [7:0] un[3];
		un = '{lph_pkg::ESC_UNS1, lph_pkg::ESC_UNS2, lph_pkg::ESC_UNS3};
		issue(lph_pkg::CMD_TURN);
		wait_oe(1'b0);
		dev.reply(lph_pkg::ESC_TE, 8'h00, 8, 1'b0, 1'b0);
		dev.reply(lph_pkg::ESC_ACK, 8'h00, 4, 1'b0, 1'b0);
		foreach (un[i]) dev.reply(un[i], 8'h00, 8, 1'b0, 1'b0);
		dev.reply(lph_pkg::ESC_ACK, 8'h00, 8, 1'b0, 1'b0);
		dev.reply(lph_pkg::ESC_LPDT, 8'hc3, 8, 1'b1, 1'b1);
		wait_oe(1'b1);
		settle();
		`CHK(n_te, 1, "tearing count")
		`CHK(n_ack, 1, "ack count")
		`CHK(rxq.size(), 1, "reply bytes")
		`CHK(rxq[0], 8'hc3, "reply data")
	endtask : t_turn

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	// whole run is a little over a thousand cycles; a hang is cut at 20k
	initial begin
		#400000;
		n_fail++;
		summarize();
	end

	initial begin
		repeat (20) @(posedge clk_i);
		`CHK({ck_p_o, ck_n_o, d0_p_o, d0_n_o}, 4'hf, "reset lines")
		#1 rst_i = 1'b0;
		t_escapes();
		t_clock();
		t_turn();
		summarize();
	end
endmodule : lph_host_bench
